/* verilog/pwc_top.sv */
/*
 Pulse width capture and square wave output block of a 16-bit timer.
 Assumes a single sys_clk with synchronous reset, software on a plain
 register port, and asynchronous pulse sources on the two timer inputs.
*/
// Notes on behaviour
// - prescaler config bits 5:4 pick input 0 edge, bits 7:6 input 1 edge
// - free-running: input 0 valid edge copies counter to capture B, raises B request
// - free-running, A in capture mode: input 1 valid edge copies counter to A, raises A request
// - inputs sampled on count clock; edge accepted after two equal samples
// - two-register mode: opposite input 0 edge copies counter into register A
// - input 0 set to both edges: no opposite-edge capture into A
// - A source select set: input 1 edge skips loading A, still raises request
// - restart mode: input 0 edge loads capture B, then clears counter to zero
// - counter wrap sets overflow flag; software ignores it for measurement
// - output enable and toggle bits set, match-clear mode: output inverts every A plus one counts
// - match-clear mode: counter equal A clears counter, raises A request
// - counter runs unless both run-mode bits are zero
`timescale 1ns/100ps
`default_nettype none

`include "pwc_defines.svh"

module pwc_top (
   input wire logic sys_clk,
   input wire logic reset,
   input wire pwc_pkg::pwc_addr_t reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire logic timer_input_zero,
   input wire logic timer_input_one,
   output logic timer_output_pin,
   output logic irq_match_a,
   output logic irq_capture_b,
   output pwc_pkg::pwc_mode_t run_mode
);

   import pwc_pkg::*;

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic run_mode_bit_lo;
   logic run_mode_bit_hi;
   logic overflow_flag;
   logic [7:0] capcmp_ctrl_reg;
   logic [7:0] output_ctrl_reg;
   logic [7:0] prescaler_edge_cfg;
   logic [15:0] compare_capture_a;
   logic [15:0] capture_reg_b;
   logic [15:0] main_counter;
   logic [5:0] div_reg;
   logic out_level_reg;
   logic irq_a_reg;
   logic irq_b_reg;
   logic [15:0] rdata_reg;

   logic [15:0] compare_capture_a_next;
   logic [15:0] capture_reg_b_next;
   logic [15:0] main_counter_next;
   logic overflow_next;
   logic out_level_next;
   pwc_mode_t mode_now;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   wire wr_mode = reg_write && (reg_addr == `PWC_ADDR_MODE);
   wire wr_capcmp = reg_write && (reg_addr == `PWC_ADDR_CAPCMP);
   wire wr_outctrl = reg_write && (reg_addr == `PWC_ADDR_OUTCTRL);
   wire wr_prescale = reg_write && (reg_addr == `PWC_ADDR_PRESCALE);
   wire wr_cca = reg_write && (reg_addr == `PWC_ADDR_CCA);
   wire wr_ccb = reg_write && (reg_addr == `PWC_ADDR_CCB);

   wire [1:0] run_bits = {run_mode_bit_hi, run_mode_bit_lo};
   wire [1:0] clk_sel = prescaler_edge_cfg[`PWC_PRE_CKSEL_LSB +: 2];
   wire [1:0] in0_edge_sel = prescaler_edge_cfg[`PWC_PRE_IN0_EDGE_LSB +: 2];
   wire [1:0] in1_edge_sel = prescaler_edge_cfg[`PWC_PRE_IN1_EDGE_LSB +: 2];
   wire a_is_capture = capcmp_ctrl_reg[`PWC_CAPCMP_A_CAPTURE_BIT];
   wire capture_a_src_sel = capcmp_ctrl_reg[`PWC_CAPCMP_A_SRC_BIT];
   wire output_enable_bit = output_ctrl_reg[`PWC_OUT_ENABLE_BIT];
   wire toggle_on_match_bit = output_ctrl_reg[`PWC_OUT_TOGGLE_BIT];

   // ----------------------------------------------------------------
   // run mode
   // ----------------------------------------------------------------
   always_comb begin
      case (run_bits)
         `PWC_RUN_STOP: mode_now = PWC_STOPPED;
         `PWC_RUN_FREE: mode_now = PWC_FREE_RUN;
         `PWC_RUN_RESTART: mode_now = PWC_RESTART;
         `PWC_RUN_MATCH: mode_now = PWC_MATCH_CLEAR;
         default: mode_now = PWC_STOPPED;
      endcase
   end

   wire running = (run_bits != `PWC_RUN_STOP);

   // ----------------------------------------------------------------
   // count clock divider
   // ----------------------------------------------------------------
   logic [5:0] div_mask;
   always_comb begin
      case (clk_sel)
         2'h0: div_mask = `PWC_DIV_MASK_0;
         2'h1: div_mask = `PWC_DIV_MASK_1;
         2'h2: div_mask = `PWC_DIV_MASK_2;
         2'h3: div_mask = `PWC_DIV_MASK_3;
         default: div_mask = `PWC_DIV_MASK_0;
      endcase
   end

   // divider runs freely so inputs are filtered even while stopped
   wire count_en = ((div_reg & div_mask) == div_mask);

   // ----------------------------------------------------------------
   // input filters
   // ----------------------------------------------------------------
   logic in0_rise;
   logic in0_fall;
   logic in1_rise;
   logic in1_fall;

   pwc_edge_filter u_filter_in0 (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin_in(timer_input_zero),
      .sample_en(count_en),
      .rise_pulse(in0_rise),
      .fall_pulse(in0_fall)
   );

   pwc_edge_filter u_filter_in1 (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin_in(timer_input_one),
      .sample_en(count_en),
      .rise_pulse(in1_rise),
      .fall_pulse(in1_fall)
   );

   // ----------------------------------------------------------------
   // valid edge qualification
   // ----------------------------------------------------------------
   logic in0_valid;
   logic in0_opposite;
   logic in1_valid;

   always_comb begin
      case (in0_edge_sel)
         `PWC_EDGE_FALL: begin
            in0_valid = in0_fall;
            in0_opposite = in0_rise;
         end
         `PWC_EDGE_RISE: begin
            in0_valid = in0_rise;
            in0_opposite = in0_fall;
         end
         `PWC_EDGE_BOTH: begin
            in0_valid = in0_rise || in0_fall;
            in0_opposite = 1'b0;
         end
         default: begin
            in0_valid = 1'b0;
            in0_opposite = 1'b0;
         end
      endcase
   end

   always_comb begin
      case (in1_edge_sel)
         `PWC_EDGE_FALL: in1_valid = in1_fall;
         `PWC_EDGE_RISE: in1_valid = in1_rise;
         `PWC_EDGE_BOTH: in1_valid = in1_rise || in1_fall;
         default: in1_valid = 1'b0;
      endcase
   end

   // a stopped timer ignores its inputs entirely
   wire cap_b_event = running && in0_valid;
   wire pin1_event = running && a_is_capture && in1_valid;
   wire load_a_pin1 = pin1_event && !capture_a_src_sel;
   wire load_a_opp = running && a_is_capture && capture_a_src_sel && in0_opposite;
   wire restart_event = (mode_now == PWC_RESTART) && cap_b_event;

   // ----------------------------------------------------------------
   // compare match and counter step
   // ----------------------------------------------------------------
   wire at_match = (main_counter == compare_capture_a);
   wire match_event = running && count_en && !a_is_capture && at_match;
   wire clear_on_match = (mode_now == PWC_MATCH_CLEAR) && match_event;
   wire [15:0] counter_inc = main_counter + 16'h0001;
   wire wrap_event = running && count_en && (main_counter == 16'hFFFF) && !clear_on_match
      && !restart_event;

   always_comb begin
      main_counter_next = main_counter;
      if (!running) begin
         // stopping also clears, so the next start counts from zero
         main_counter_next = `PWC_RST_WORD16;
      end else if (restart_event || clear_on_match) begin
         main_counter_next = `PWC_RST_WORD16;
      end else if (count_en) begin
         main_counter_next = counter_inc;
      end
   end

   // capture value is the count before this edge's increment
   always_comb begin
      capture_reg_b_next = capture_reg_b;
      if (cap_b_event) begin
         capture_reg_b_next = main_counter;
      end else if (wr_ccb) begin
         capture_reg_b_next = reg_wdata;
      end
   end

   always_comb begin
      compare_capture_a_next = compare_capture_a;
      if (load_a_pin1 || load_a_opp) begin
         compare_capture_a_next = main_counter;
      end else if (wr_cca) begin
         compare_capture_a_next = reg_wdata;
      end
   end

   // hardware set wins over a software clear in the same cycle
   always_comb begin
      overflow_next = overflow_flag;
      if (wr_mode && !reg_wdata[`PWC_MODE_OVF_BIT]) begin
         overflow_next = 1'b0;
      end
      if (wrap_event) begin
         overflow_next = 1'b1;
      end
   end

   // square wave: toggles once per A plus one counts in match-clear mode
   always_comb begin
      out_level_next = out_level_reg;
      if (!output_enable_bit) begin
         out_level_next = 1'b0;
      end else if (toggle_on_match_bit && match_event) begin
         out_level_next = !out_level_reg;
      end
   end

   // ----------------------------------------------------------------
   // read data mux
   // ----------------------------------------------------------------
   logic [15:0] read_mux;
   always_comb begin
      case (reg_addr)
         `PWC_ADDR_MODE: read_mux = {12'h000, run_bits, 1'b0, overflow_flag};
         `PWC_ADDR_CAPCMP: read_mux = {8'h00, capcmp_ctrl_reg};
         `PWC_ADDR_OUTCTRL: read_mux = {8'h00, output_ctrl_reg};
         `PWC_ADDR_PRESCALE: read_mux = {8'h00, prescaler_edge_cfg};
         `PWC_ADDR_CCA: read_mux = compare_capture_a;
         `PWC_ADDR_CCB: read_mux = capture_reg_b;
         `PWC_ADDR_COUNTER: read_mux = main_counter;
         default: read_mux = 16'h0000;
      endcase
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         run_mode_bit_lo <= 1'b0;
         run_mode_bit_hi <= 1'b0;
         capcmp_ctrl_reg <= `PWC_RST_CTRL8;
         output_ctrl_reg <= `PWC_RST_CTRL8;
         prescaler_edge_cfg <= `PWC_RST_CTRL8;
      end else begin
         if (wr_mode) begin
            run_mode_bit_lo <= reg_wdata[`PWC_MODE_RUN_LO_BIT];
            run_mode_bit_hi <= reg_wdata[`PWC_MODE_RUN_HI_BIT];
         end
         if (wr_capcmp) begin
            capcmp_ctrl_reg <= reg_wdata[7:0];
         end
         if (wr_outctrl) begin
            output_ctrl_reg <= reg_wdata[7:0];
         end
         if (wr_prescale) begin
            prescaler_edge_cfg <= reg_wdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // counting, capture and output state
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         main_counter <= `PWC_RST_WORD16;
         compare_capture_a <= `PWC_RST_WORD16;
         capture_reg_b <= `PWC_RST_WORD16;
         overflow_flag <= 1'b0;
         out_level_reg <= 1'b0;
         div_reg <= 6'h00;
      end else begin
         main_counter <= main_counter_next;
         compare_capture_a <= compare_capture_a_next;
         capture_reg_b <= capture_reg_b_next;
         overflow_flag <= overflow_next;
         out_level_reg <= out_level_next;
         div_reg <= div_reg + 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // interrupt request pulses and read data
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_a_reg <= 1'b0;
         irq_b_reg <= 1'b0;
         rdata_reg <= 16'h0000;
      end else begin
         irq_a_reg <= match_event || pin1_event;
         irq_b_reg <= cap_b_event;
         rdata_reg <= reg_read ? read_mux : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata = rdata_reg;
   assign timer_output_pin = out_level_reg;
   assign irq_match_a = irq_a_reg;
   assign irq_capture_b = irq_b_reg;
   assign run_mode = mode_now;

endmodule

`default_nettype wire

/* verilog/pwc_defines.svh */
/*
 Register offsets, field positions, reset values and divider masks of the
 pulse width capture and square wave block.
 Assumes it is included by bare name at file scope, ahead of the module that uses it.
*/
`ifndef PWC_DEFINES_SVH
`define PWC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define PWC_ADDR_MODE 3'h0
`define PWC_ADDR_CAPCMP 3'h1
`define PWC_ADDR_OUTCTRL 3'h2
`define PWC_ADDR_PRESCALE 3'h3
`define PWC_ADDR_CCA 3'h4
`define PWC_ADDR_CCB 3'h5
`define PWC_ADDR_COUNTER 3'h6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PWC_MODE_OVF_BIT 0
`define PWC_MODE_RUN_LO_BIT 2
`define PWC_MODE_RUN_HI_BIT 3
`define PWC_CAPCMP_A_CAPTURE_BIT 0
`define PWC_CAPCMP_A_SRC_BIT 1
`define PWC_OUT_ENABLE_BIT 0
`define PWC_OUT_TOGGLE_BIT 1
`define PWC_PRE_CKSEL_LSB 0
`define PWC_PRE_IN0_EDGE_LSB 4
`define PWC_PRE_IN1_EDGE_LSB 6

// ----------------------------------------------------------------
// edge select codes and run mode codes
// ----------------------------------------------------------------
`define PWC_EDGE_FALL 2'h0
`define PWC_EDGE_RISE 2'h1
`define PWC_EDGE_NONE 2'h2
`define PWC_EDGE_BOTH 2'h3
`define PWC_RUN_STOP 2'h0
`define PWC_RUN_FREE 2'h1
`define PWC_RUN_RESTART 2'h2
`define PWC_RUN_MATCH 2'h3

// ----------------------------------------------------------------
// reset values and count clock divider masks
// ----------------------------------------------------------------
`define PWC_RST_CTRL8 8'h00
`define PWC_RST_WORD16 16'h0000
`define PWC_DIV_MASK_0 6'h00
`define PWC_DIV_MASK_1 6'h03
`define PWC_DIV_MASK_2 6'h0F
`define PWC_DIV_MASK_3 6'h3F

`endif

/* verilog/pwc_pkg.sv */
/*
 Types shared by the pulse width capture and square wave block.
 Assumes pwc_defines.svh is on the include path.
*/
package pwc_pkg;

   typedef logic [2:0] pwc_addr_t;

   typedef enum logic [1:0] {
      PWC_STOPPED,
      PWC_FREE_RUN,
      PWC_RESTART,
      PWC_MATCH_CLEAR
   } pwc_mode_t;

endpackage

/* verilog/pwc_edge_filter.sv */
/*
 Two-sample noise filter and edge detector for one timer input pin.
 Assumes pin_in is asynchronous and sample_en is a one-cycle pulse on sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module pwc_edge_filter (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic pin_in,
   input wire logic sample_en,
   output logic rise_pulse,
   output logic fall_pulse
);

   logic sync1_reg;
   logic sync2_reg;
   logic sample_reg;
   logic level_reg;
   wire accept;

   // ----------------------------------------------------------------
   // synchroniser and sampled level
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sample_reg <= 1'b0;
         level_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         if (sample_en) begin
            sample_reg <= sync2_reg;
            if (accept) begin
               level_reg <= sync2_reg;
            end
         end
      end
   end

   // new level must be seen on two consecutive count clock samples
   assign accept = (sync2_reg == sample_reg) && (sync2_reg != level_reg);
   assign rise_pulse = sample_en && accept && sync2_reg;
   assign fall_pulse = sample_en && accept && !sync2_reg;

endmodule

`default_nettype wire

/* testbench/pwc_assertions.sv */
/*
 Port checker for pwc_top: bus answers, request pulses, square wave timing.
 Assumes one sys_clk, synchronous reset, and the bind at the foot of this file.
*/
`timescale 1ns/100ps
`default_nettype none

module pwc_assertions (
   input wire logic sys_clk,
   input wire logic reset,
   input wire pwc_pkg::pwc_addr_t reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_rdata,
   input wire logic timer_input_zero,
   input wire logic timer_input_one,
   input wire logic timer_output_pin,
   input wire logic irq_match_a,
   input wire logic irq_capture_b,
   input wire pwc_pkg::pwc_mode_t run_mode
);
   import pwc_pkg::*;
   // ----------------------------------------------------------------
   // helper state
   // ----------------------------------------------------------------
   logic out_q;
   logic gap_ok;
   logic [1:0] sel_sh;
   logic [15:0] a_sh;
   logic [23:0] gap_cnt;
   wire logic toggle;
   wire logic [23:0] gap_exp;
   assign toggle = timer_output_pin ^ out_q;
   // shadows follow software writes only, so the gap check is
   // limited to match-clear mode toggles, which need A in compare mode, where no capture touches A
   assign gap_exp = ({8'h00, a_sh} + 24'h000001) << {sel_sh, 1'b0};
   always_ff @(posedge sys_clk) begin
      out_q <= reset ? 1'b0 : timer_output_pin;
      if (reset || (reg_write && reg_addr == 3'h4)) a_sh <= reset ? 16'h0000 : reg_wdata;
      if (reset || (reg_write && reg_addr == 3'h3)) sel_sh <= reset ? 2'h0 : reg_wdata[1:0];
      gap_cnt <= toggle ? 24'h000001 : gap_cnt + 24'h000001;
      gap_ok <= !reset && !reg_write && run_mode == PWC_MATCH_CLEAR && (gap_ok || toggle);
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   sequence s_cnt_read;
      reg_read && reg_addr == 3'h6 && run_mode == PWC_FREE_RUN && sel_sh == 2'h0;
   endsequence
   sequence s_cnt_pair;
      s_cnt_read ##1 s_cnt_read;
   endsequence
   sequence s_match_run;
      run_mode == PWC_MATCH_CLEAR ##1 run_mode == PWC_MATCH_CLEAR;
   endsequence
   property p_cnt_step;
      s_cnt_pair |=> reg_rdata == $past(reg_rdata) + 16'h0001;
   endproperty
   property p_irq_b_pulse;
      irq_capture_b |=> !irq_capture_b;
   endproperty
   property p_irq_a_pulse;
      irq_match_a && a_sh != 16'h0000 |=> !irq_match_a;
   endproperty
   property p_stop_quiet;
      run_mode == PWC_STOPPED && $past(run_mode) == PWC_STOPPED |-> !irq_capture_b && !irq_match_a;
   endproperty
   property p_toggle_irq;
      s_match_run ##0 toggle |-> irq_match_a;
   endproperty
   property p_square_gap;
      gap_ok && toggle |-> gap_cnt == gap_exp;
   endproperty
   property p_rdata_idle;
      !$past(reg_read) |-> reg_rdata == 16'h0000;
   endproperty
   property p_unmapped;
      reg_read && reg_addr == 3'h7 |=> reg_rdata == 16'h0000;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter step wrong");
   a_irq_b_pulse: assert property (p_irq_b_pulse) else $error("b request too long");
   a_irq_a_pulse: assert property (p_irq_a_pulse) else $error("a request too long");
   a_stop_quiet: assert property (p_stop_quiet) else $error("request while stopped");
   a_toggle_irq: assert property (p_toggle_irq) else $error("toggle without match");
   a_square_gap: assert property (p_square_gap) else $error("square half period wrong");
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   a_unmapped: assert property (p_unmapped) else $error("unmapped index not zero");
endmodule

bind pwc_top pwc_assertions pwc_assertions_inst (
   .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .timer_input_zero(timer_input_zero), .timer_input_one(timer_input_one),
   .timer_output_pin(timer_output_pin), .irq_match_a(irq_match_a),
   .irq_capture_b(irq_capture_b), .run_mode(run_mode)
);
`default_nettype wire

/* testbench/pwc_pulse_src.sv */
/*
 Pulse source model for the two timer input pins.
 Assumes its tasks are called just after a rising edge of sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module pwc_pulse_src (
   input wire logic sys_clk,
   output logic pin0,
   output logic pin1
);
   initial begin
      pin0 = 1'b0;
      pin1 = 1'b0;
   end
   task automatic drive(input int which, input logic lvl);
      if (which == 0) pin0 <= lvl;
      else pin1 <= lvl;
   endtask
   // widths stay far below one counter cycle; longer ones cannot be measured
   task automatic pulse(input int which, input int width);
      drive(which, 1'b1);
      repeat (width) @(posedge sys_clk);
      drive(which, 1'b0);
      @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

/* testbench/pwc_top_tb_top.sv */
/*
 Self-checking bench for pwc_top with a pulse source on both inputs.
 Assumes pwc_pkg, the checker with its bind and the pulse source come first.
*/
`timescale 1ns/100ps
`default_nettype none

module pwc_top_tb_top;
   import pwc_pkg::*;
   logic sys_clk;
   logic reset;
   pwc_addr_t reg_addr;
   logic [15:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic [15:0] reg_rdata;
   logic pin0;
   logic pin1;
   logic out_pin;
   logic irq_a;
   logic irq_b;
   pwc_mode_t run_mode;
   int n_errors = 0;
   int check_count = 0;
   int seed = 75960;
   int na = 0;
   int nb = 0;
   int w;
   int a;
   int k;
   int c;
   logic [15:0] d0;
   logic [15:0] d1;
   pwc_top pwc_top_inst (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .timer_input_zero(pin0), .timer_input_one(pin1),
      .timer_output_pin(out_pin), .irq_match_a(irq_a), .irq_capture_b(irq_b),
      .run_mode(run_mode));
   pwc_pulse_src pwc_pulse_src_inst (.sys_clk(sys_clk), .pin0(pin0), .pin1(pin1));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (irq_a === 1'b1) na++;
      if (irq_b === 1'b1) nb++;
   end
   // ----------------------------------------------------------------
   // tasks and expectations
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input pwc_addr_t ad, input logic [15:0] dt);
      reg_addr <= ad;
      reg_wdata <= dt;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input pwc_addr_t ad, output logic [15:0] dt);
      reg_addr <= ad;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 dt = reg_rdata;
      @(posedge sys_clk);
   endtask
   task automatic rd_pair(output logic [15:0] x, output logic [15:0] y);
      reg_addr <= 3'h6;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      #1 x = reg_rdata;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 y = reg_rdata;
      @(posedge sys_clk);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wait_toggle(output logic [15:0] n);
      logic last;
      last = out_pin;
      n = 16'h0000;
      // look just after the edge, once the new output level has settled
      while (out_pin === last && n < 16'h1000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n >= 16'h1000) begin
         n_errors++;
         report_and_stop();
      end
   endtask
   // edge code 0 fall, 1 rise, 2 none, 3 both
   function automatic logic [15:0] hits(input logic [1:0] code, input logic fell);
      hits = 16'(code == 2'h1 || code == 2'h3) + 16'(fell && (code == 2'h0 || code == 2'h3));
   endfunction
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      reg_addr = 3'h0;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      wr(3'h7, 16'hFFFF);
      for (k = 0; k < 8; k++) begin
         rd(k[2:0], d0);
         chk(d0, 16'h0000);
      end
      chk(16'(run_mode), 16'(PWC_STOPPED));
      wr(3'h1, 16'h0001);
      wr(3'h3, 16'h00A0);
      wr(3'h0, 16'h0004);
      chk(16'(run_mode), 16'(PWC_FREE_RUN));
      rd_pair(d0, d1);
      chk(d1 - d0, 16'h0001);
      for (k = 0; k < 8; k++) begin
         wr(3'h3, k < 4 ? {8'h00, 2'h2, k[1:0], 4'h0} : {8'h00, k[1:0], 2'h2, 4'h0});
         c = k < 4 ? nb : na;
         pwc_pulse_src_inst.drive(k / 4, 1'b1);
         idle(12);
         chk(16'((k < 4 ? nb : na) - c), hits(k[1:0], 1'b0));
         pwc_pulse_src_inst.drive(k / 4, 1'b0);
         idle(12);
         chk(16'((k < 4 ? nb : na) - c), hits(k[1:0], 1'b1));
      end
      wr(3'h3, 16'h00F0);
      c = nb;
      pwc_pulse_src_inst.pulse(0, 1);
      idle(12);
      chk(16'(nb - c), 16'h0000);
      w = 4 + ($unsigned($random(seed)) % 40);
      a = 4 + ($unsigned($random(seed)) % 40);
      c = nb;
      k = na;
      fork
         pwc_pulse_src_inst.pulse(0, w);
         pwc_pulse_src_inst.pulse(1, a);
      join
      idle(12);
      rd(3'h5, d0);
      rd(3'h4, d1);
      chk(d0 - d1, 16'(w - a));
      chk(16'(nb - c), 16'h0002);
      chk(16'(na - k), 16'h0002);
      wr(3'h1, 16'h0003);
      wr(3'h3, 16'h00D0);
      c = na;
      pwc_pulse_src_inst.pulse(0, w);
      idle(12);
      rd(3'h5, d0);
      rd(3'h4, d1);
      chk(d1 - d0, 16'(w));
      chk(16'(na - c), 16'h0000);
      pwc_pulse_src_inst.pulse(1, a);
      idle(12);
      rd(3'h4, d0);
      chk(d0, d1);
      chk(16'(na - c), 16'h0002);
      wr(3'h3, 16'h00F0);
      wr(3'h4, 16'h1234);
      pwc_pulse_src_inst.pulse(0, w);
      idle(12);
      rd(3'h4, d0);
      chk(d0, 16'h1234);
      wr(3'h1, 16'h0000);
      wr(3'h3, 16'h0030);
      wr(3'h0, 16'h0008);
      pwc_pulse_src_inst.pulse(0, w);
      idle(12);
      rd(3'h5, d0);
      chk(d0, 16'(w - 1));
      for (k = 0; k < 4; k++) begin
         wr(3'h0, 16'h0000);
         wr(3'h2, 16'h0000);
         a = 1 + ($unsigned($random(seed)) % 30);
         wr(3'h3, 16'(k));
         wr(3'h1, 16'h0000);
         wr(3'h2, 16'h0003);
         wr(3'h4, 16'(a));
         wr(3'h0, 16'h000C);
         wait_toggle(d0);
         wait_toggle(d0);
         chk(d0, 16'((a + 1) << (2 * k)));
      end
      wr(3'h0, 16'h0000);
      wr(3'h2, 16'h0000);
      wr(3'h3, 16'h0000);
      wr(3'h0, 16'h0004);
      rd(3'h0, d0);
      chk(d0, 16'h0004);
      // a full wrap at the fastest count clock is the only way to reach it
      idle(65540);
      rd(3'h0, d0);
      chk(d0, 16'h0005);
      wr(3'h0, 16'h0004);
      rd(3'h0, d0);
      chk(d0, 16'h0004);
      report_and_stop();
   end
endmodule
`default_nettype wire
